// ==== inc/dma_irq_pkg.sv ====
// Shared constants and types for the DMA interrupt configuration block.
`default_nettype none
package dma_irq_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte offsets in the module's register space).
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_CONFIG = 12'h008;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h012;
  localparam logic [11:0] OFS_STATUS_ID  = 12'h020;

  // ------------------------------------------------------------------
  // Field positions of the configuration register.
  // ------------------------------------------------------------------
  localparam int BIT_BYTE_MODE = 15;
  localparam int BIT_SRC_SEL   = 14;
  localparam int BIT_ARM_HI    = 13;
  localparam int BIT_ARM_LO    = 11;
  localparam int BIT_PENDING   = 7;
  localparam int LVL_MSB       = 2;

  // Field positions of the enable register.
  localparam int BIT_EN_KEY    = 11;
  localparam int BIT_EN_VALUE  = 8;

  // Status/ID register: bits 7-3 writable, bits 2-0 fixed.
  localparam int          SID_LSB   = 3;
  localparam logic [2:0]  SID_FIXED = 3'h3;

  // ------------------------------------------------------------------
  // Values after hard reset and timing counts.
  // ------------------------------------------------------------------
  localparam logic [2:0]  LVL_RST   = 3'h0;
  localparam logic [4:0]  SID_RST   = 5'h00;
  localparam int          IACK_TIMEOUT_CYC = 64;

  // Width of an acknowledge cycle, one-hot.
  typedef enum logic [2:0] {
    IACK_W8  = 3'b001,
    IACK_W16 = 3'b010,
    IACK_W32 = 3'b100
  } iack_width_e;

endpackage
`default_nettype wire

// ==== inc/dma_irq_if.sv ====
// Interface joining the interrupting device and the acknowledging handler.
`timescale 1ns/1ns
`default_nettype none
interface dma_irq_if;
  import dma_irq_pkg::*;

  logic [7:1]  irq_o;       // Open-drain drive value, always low.
  logic [7:1]  irq_oe;      // High while the device pulls a request line.
  logic [7:1]  irq_n;       // Resolved request lines, active low.
  logic        iack_req;    // Acknowledge cycle in progress.
  logic [2:0]  iack_level;  // Level being acknowledged.
  iack_width_e iack_width;  // Data width of the acknowledge cycle.
  logic        iack_dtack;  // Device has placed its status/ID.
  logic [15:0] iack_data;   // Status/ID returned by the device.

  // Wired-OR of the open-drain request lines; pulled up when undriven.
  assign irq_n = ~(irq_oe & ~irq_o);

  modport dev (
    output irq_o, irq_oe, iack_dtack, iack_data,
    input  iack_req, iack_level, iack_width
  );

  modport hdl (
    input  irq_n, iack_dtack, iack_data,
    output iack_req, iack_level, iack_width
  );
endinterface
`default_nettype wire

// ==== core/dma_irq_dev.sv ====
// Interrupt configuration, status and acknowledge logic of the device end.
`timescale 1ns/1ns
`default_nettype none
module dma_irq_dev
  import dma_irq_pkg::*;
(
  input  wire logic        core_clk,    // System clock.
  input  wire logic        srst,        // Hard reset, clears configuration.
  input  wire logic        soft_rst,    // Soft reset, keeps configuration.
  input  wire logic        reg_wr,      // Register write strobe.
  input  wire logic        reg_rd,      // Register read strobe.
  input  wire logic [11:0] reg_addr,    // Register byte offset.
  input  wire logic [1:0]  reg_be,      // Byte enables: 1 is 15-8, 0 is 7-0.
  input  wire logic [15:0] reg_wdata,   // Write data.
  output logic      [15:0] reg_rdata,   // Read data, valid with reg_ack.
  output logic             reg_ack,     // Access completed.
  input  wire logic [7:0]  logical_addr,// Module logical address.
  input  wire logic        dma_done,    // Shared DMA completion condition.
  output logic             irq_pending, // Copy of the pending flag.
  dma_irq_if.dev           bus          // Request lines and acknowledge.
);

  // ------------------------------------------------------------------
  // State registers.
  // ------------------------------------------------------------------
  logic       byte_mode_r, byte_mode_nxt;   // Byte status/ID mode.
  logic       src_sel_r,   src_sel_nxt;     // Logical address as status/ID.
  logic [1:0] arm_r,       arm_nxt;         // Bits that must be set to 1.
  logic [2:0] lvl_r,       lvl_nxt;         // Request level.
  logic [4:0] sid_r,       sid_nxt;         // Writable status/ID bits.
  logic       en_r,        en_nxt;          // Interrupt enabled.
  logic       pend_r,      pend_nxt;        // Pending flag.
  logic       rel_r,       rel_nxt;         // Request released by acknowledge.
  logic       dtack_r,     dtack_nxt;       // Acknowledge answered.
  logic [15:0] idata_r,    idata_nxt;       // Status/ID on the bus.
  logic [7:1] oe_r,        oe_nxt;          // Request line enables.
  logic [15:0] rdata_r,    rdata_nxt;       // Read data.
  logic       ack_r,       ack_nxt;         // Access acknowledge.

  // ------------------------------------------------------------------
  // Combinational helpers.
  // ------------------------------------------------------------------
  logic        wr_cfg;     // Write to the configuration register.
  logic        wr_en;      // Write to the enable register.
  logic        wr_sid;     // Write to the status/ID register.
  logic [7:0]  sid_byte;   // Full status/ID register value.
  logic [15:0] cfg_rd;     // Configuration register read view.
  logic        width_ok;   // Acknowledge width is one we answer.
  logic        take_iack;  // Acknowledge cycle is ours this cycle.
  logic        asserting;  // Device requests on its level.

  assign wr_cfg   = reg_wr && (reg_addr == OFS_IRQ_CONFIG);
  assign wr_en    = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
  assign wr_sid   = reg_wr && (reg_addr == OFS_STATUS_ID);
  assign sid_byte = {sid_r, SID_FIXED};

  // Reserved bits 12, 10-8 and 6-3 read as zero; any value is allowed.
  always_comb begin
    cfg_rd                = 16'h0000;
    cfg_rd[BIT_BYTE_MODE] = byte_mode_r;
    cfg_rd[BIT_SRC_SEL]   = src_sel_r;
    cfg_rd[BIT_ARM_HI]    = arm_r[1];
    cfg_rd[BIT_ARM_LO]    = arm_r[0];
    cfg_rd[BIT_PENDING]   = pend_r;
    cfg_rd[LVL_MSB:0]     = lvl_r;
  end

  // Without byte mode, 8-bit acknowledge cycles are not answered at all.
  assign width_ok  = byte_mode_r || (bus.iack_width != IACK_W8);

  // A level of zero never matches, so an unprogrammed level stays silent.
  assign asserting = pend_r && en_r && (&arm_r) && !rel_r && (lvl_r != 3'h0);
  assign take_iack = bus.iack_req && !dtack_r && asserting &&
                     (bus.iack_level == lvl_r) && width_ok;

  // ------------------------------------------------------------------
  // Configuration and register-file next state.
  // ------------------------------------------------------------------
  // Hard reset (srst) alone clears these; soft reset leaves them alone.
  always_comb begin
    byte_mode_nxt = byte_mode_r;
    src_sel_nxt   = src_sel_r;
    arm_nxt       = arm_r;
    lvl_nxt       = lvl_r;
    sid_nxt       = sid_r;
    en_nxt        = en_r;
    // High byte of the configuration register.
    if (wr_cfg && reg_be[1]) begin
      byte_mode_nxt = reg_wdata[BIT_BYTE_MODE];
      // Software keeps this bit clear unless byte mode is on.
      src_sel_nxt   = reg_wdata[BIT_SRC_SEL];
      arm_nxt       = {reg_wdata[BIT_ARM_HI], reg_wdata[BIT_ARM_LO]};
    end
    // Low byte: level field; pending and reserved bits ignore writes.
    if (wr_cfg && reg_be[0]) begin
      lvl_nxt = reg_wdata[LVL_MSB:0];
    end
    // Enable register: the key bit must be 1 for the value bit to count.
    if (wr_en && reg_be[1] && reg_wdata[BIT_EN_KEY]) begin
      en_nxt = reg_wdata[BIT_EN_VALUE];
    end
    if (wr_sid && reg_be[0]) begin
      sid_nxt = reg_wdata[7:SID_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Read path next state.
  // ------------------------------------------------------------------
  // Every strobe is answered one cycle later; unmapped offsets read zero.
  always_comb begin
    ack_nxt   = reg_wr || reg_rd;
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_IRQ_CONFIG: rdata_nxt = cfg_rd;
        OFS_IRQ_ENABLE: rdata_nxt = {4'h0, en_r, 11'h000};
        OFS_STATUS_ID:  rdata_nxt = {8'h00, sid_byte};
        default:        rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Pending flag, request lines and acknowledge next state.
  // ------------------------------------------------------------------
  // The flag clears only once the interrupt is disabled and the done
  // condition has gone; a new done in that same cycle keeps it set.
  always_comb begin
    pend_nxt  = pend_r;
    rel_nxt   = rel_r;
    dtack_nxt = dtack_r;
    idata_nxt = idata_r;
    if (dma_done) begin
      pend_nxt = 1'b1;
    end else if (!en_r) begin
      pend_nxt = 1'b0;
    end
    // Acknowledge releases the line but leaves the flag untouched.
    if (take_iack) begin
      rel_nxt   = 1'b1;
      dtack_nxt = 1'b1;
      if (byte_mode_r) begin
        // Byte answer in the low lane, whatever the cycle width.
        idata_nxt = {8'h00, src_sel_r ? logical_addr : sid_byte};
      end else begin
        idata_nxt = {sid_byte, logical_addr};
      end
    end else if (!bus.iack_req) begin
      dtack_nxt = 1'b0;
    end
    // A released request is armed again once the flag clears or on soft reset.
    if (!pend_nxt) begin
      rel_nxt = 1'b0;
    end
    // Soft reset abandons any acknowledge in progress.
    if (soft_rst) begin
      dtack_nxt = 1'b0;
      rel_nxt   = 1'b0;
    end
  end

  // One line per level; only the line equal to the level field is pulled.
  always_comb begin
    for (int i = 1; i <= 7; i++) begin
      oe_nxt[i] = pend_nxt && en_nxt && (&arm_nxt) && !rel_nxt &&
                  (lvl_nxt == 3'(i));
    end
  end

  // ------------------------------------------------------------------
  // Registers.
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      byte_mode_r <= 1'b0;
      src_sel_r   <= 1'b0;
      arm_r       <= 2'h0;
      lvl_r       <= LVL_RST;
      sid_r       <= SID_RST;
      en_r        <= 1'b0;
      pend_r      <= 1'b0;
      rel_r       <= 1'b0;
      dtack_r     <= 1'b0;
      idata_r     <= 16'h0000;
      oe_r        <= 7'h00;
      rdata_r     <= 16'h0000;
      ack_r       <= 1'b0;
    end else begin
      byte_mode_r <= byte_mode_nxt;
      src_sel_r   <= src_sel_nxt;
      arm_r       <= arm_nxt;
      lvl_r       <= lvl_nxt;
      sid_r       <= sid_nxt;
      en_r        <= en_nxt;
      pend_r      <= pend_nxt;
      rel_r       <= rel_nxt;
      dtack_r     <= dtack_nxt;
      idata_r     <= idata_nxt;
      oe_r        <= oe_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flip-flops except irq_o, which is tied low.
  // ------------------------------------------------------------------
  assign reg_rdata      = rdata_r;
  assign reg_ack        = ack_r;
  assign irq_pending    = pend_r;
  assign bus.irq_oe     = oe_r;
  assign bus.irq_o      = 7'h00;
  assign bus.iack_dtack = dtack_r;
  assign bus.iack_data  = idata_r;

endmodule
`default_nettype wire

// ==== core/dma_irq_hdl.sv ====
// Interrupt handler end: watches request lines and runs acknowledge cycles.
`timescale 1ns/1ns
`default_nettype none
module dma_irq_hdl
  import dma_irq_pkg::*;
#(
  parameter int TIMEOUT_CYC = IACK_TIMEOUT_CYC  // Cycles before giving up.
)(
  input  wire logic        core_clk,   // System clock.
  input  wire logic        srst,       // Synchronous reset.
  input  wire logic        cmd_start,  // Start an acknowledge cycle.
  input  wire logic [2:0]  cmd_level,  // Level to acknowledge.
  input  wire iack_width_e cmd_width,  // Width of the cycle.
  output logic             busy,       // Cycle in progress.
  output logic             resp_valid, // Pulse: status/ID captured.
  output logic      [15:0] resp_data,  // Captured status/ID.
  output logic             resp_timeout,// Pulse: nobody answered.
  output logic      [7:1]  irq_seen,   // Request lines, active high.
  dma_irq_if.hdl           bus         // Request lines and acknowledge.
);

  // ------------------------------------------------------------------
  // States.
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DROP = 3'b100
  } hdl_state_e;

  hdl_state_e  st_r,    st_nxt;     // Handshake state.
  logic        req_r,   req_nxt;    // Acknowledge request.
  logic [2:0]  lvl_r,   lvl_nxt;    // Level on the bus.
  iack_width_e wid_r,   wid_nxt;    // Width on the bus.
  logic [7:0]  cnt_r,   cnt_nxt;    // Timeout counter.
  logic        val_r,   val_nxt;    // Response pulse.
  logic        tmo_r,   tmo_nxt;    // Timeout pulse.
  logic [15:0] data_r,  data_nxt;   // Captured data.
  logic [7:1]  seen_r;              // Registered request lines.

  localparam logic [7:0] TMO_LAST = 8'(TIMEOUT_CYC - 1);

  // ------------------------------------------------------------------
  // Handshake next state.
  // ------------------------------------------------------------------
  // The request is held until the device answers or the counter runs out;
  // a new cycle waits for the answer of the last one to drop.
  always_comb begin
    st_nxt   = st_r;
    req_nxt  = req_r;
    lvl_nxt  = lvl_r;
    wid_nxt  = wid_r;
    cnt_nxt  = cnt_r;
    val_nxt  = 1'b0;
    tmo_nxt  = 1'b0;
    data_nxt = data_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_start) begin
          st_nxt  = ST_WAIT;
          req_nxt = 1'b1;
          lvl_nxt = cmd_level;
          wid_nxt = cmd_width;
          cnt_nxt = 8'h00;
        end
      end
      ST_WAIT: begin
        if (bus.iack_dtack) begin
          // An 8-bit cycle only carries the low lane.
          data_nxt = (wid_r == IACK_W8) ? {8'h00, bus.iack_data[7:0]}
                                        : bus.iack_data;
          val_nxt  = 1'b1;
          req_nxt  = 1'b0;
          st_nxt   = ST_DROP;
        end else if (cnt_r == TMO_LAST) begin
          tmo_nxt  = 1'b1;
          req_nxt  = 1'b0;
          st_nxt   = ST_DROP;
        end else begin
          cnt_nxt  = cnt_r + 8'h01;
        end
      end
      ST_DROP: begin
        if (!bus.iack_dtack) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Registers.
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r   <= ST_IDLE;
      req_r  <= 1'b0;
      lvl_r  <= 3'h0;
      wid_r  <= IACK_W16;
      cnt_r  <= 8'h00;
      val_r  <= 1'b0;
      tmo_r  <= 1'b0;
      data_r <= 16'h0000;
      seen_r <= 7'h00;
    end else begin
      st_r   <= st_nxt;
      req_r  <= req_nxt;
      lvl_r  <= lvl_nxt;
      wid_r  <= wid_nxt;
      cnt_r  <= cnt_nxt;
      val_r  <= val_nxt;
      tmo_r  <= tmo_nxt;
      data_r <= data_nxt;
      seen_r <= ~bus.irq_n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------------
  assign busy           = (st_r != ST_IDLE);
  assign resp_valid     = val_r;
  assign resp_data      = data_r;
  assign resp_timeout   = tmo_r;
  assign irq_seen       = seen_r;
  assign bus.iack_req   = req_r;
  assign bus.iack_level = lvl_r;
  assign bus.iack_width = wid_r;

endmodule
`default_nettype wire

// ==== tb/dma_irq_sva.sv ====
// Concurrent checks on the request lines and the acknowledge handshake.
`timescale 1ns/1ns
`default_nettype none
module dma_irq_sva
  import dma_irq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [7:1]  irq_o,
  input wire logic [7:1]  irq_oe,
  input wire logic [7:1]  irq_n,
  input wire logic        iack_req,
  input wire logic [2:0]  iack_level,
  input wire iack_width_e iack_width,
  input wire logic        iack_dtack,
  input wire logic [15:0] iack_data
);
  // Bit 0 is the enable of the line being acknowledged; level 0 hits nothing.
  logic [7:0] lvl_v;
  assign lvl_v = {irq_oe, 1'b0} >> iack_level;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ------------------------------------------------------------------
  // Sequences of the acknowledge cycle.
  // ------------------------------------------------------------------
  sequence s_req_open;
    iack_req && !iack_dtack;
  endsequence
  sequence s_answer;
    iack_dtack && irq_oe == 7'h00;
  endsequence

  // A 16/32-bit cycle on the driven level is answered next cycle, line released.
  property p_take;
    s_req_open ##0 (iack_width != IACK_W8 && lvl_v[0]) |=> s_answer;
  endproperty
  // A cycle on a level that is not driven is never answered.
  property p_refuse;
    s_req_open ##0 !lvl_v[0] |=> !iack_dtack;
  endproperty
  property p_cause;
    $rose(iack_dtack) |-> $past(iack_req) && $past(lvl_v[0]);
  endproperty
  property p_byte;
    iack_dtack && iack_width == IACK_W8 |-> iack_data[15:8] == 8'h00;
  endproperty
  property p_hold;
    iack_dtack && iack_req |=> iack_dtack && $stable(iack_data);
  endproperty
  property p_drop;
    iack_dtack && !iack_req |=> !iack_dtack;
  endproperty
  property p_onehot;
    $onehot0(irq_oe);
  endproperty
  // Open drain: the drive value is always low, so the wire follows the enables.
  property p_od;
    irq_o == 7'h00 && irq_n == ~irq_oe;
  endproperty
  property p_steady;
    irq_oe != 7'h00 |=> irq_oe == 7'h00 || $stable(irq_oe);
  endproperty

  a_take: assert property (p_take) else $error("acknowledge not answered");
  a_refuse: assert property (p_refuse) else $error("answer on idle level");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_byte: assert property (p_byte) else $error("byte answer upper bits set");
  a_hold: assert property (p_hold) else $error("answer did not stand");
  a_drop: assert property (p_drop) else $error("answer not withdrawn");
  a_onehot: assert property (p_onehot) else $error("several lines driven");
  a_od: assert property (p_od) else $error("request line level wrong");
  a_steady: assert property (p_steady) else $error("driven line moved");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench joining the device end and the handler end.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dma_irq_pkg::*;
  logic        core_clk, srst, soft_rst, reg_wr, reg_rd, dma_done, cmd_start;
  logic        reg_ack, irq_pending, busy, resp_valid, resp_timeout, bm, ss, ok;
  logic [11:0] reg_addr;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata, reg_rdata, resp_data, q, cfg;
  logic [7:0]  logical_addr, sid, la;
  logic [2:0]  cmd_level, lvl;
  iack_width_e cmd_width, w;
  logic [7:1]  irq_seen;
  logic [31:0] seed = 32'had006957;
  logic [31:0] r;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  dma_irq_if bus_if ();
  dma_irq_dev dma_irq_dev_i (.core_clk(core_clk), .srst(srst), .soft_rst(soft_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .logical_addr(logical_addr), .dma_done(dma_done), .irq_pending(irq_pending), .bus(bus_if));
  // A short timeout keeps refused cycles cheap.
  dma_irq_hdl #(.TIMEOUT_CYC(4)) dma_irq_hdl_i (.core_clk(core_clk), .srst(srst),
    .cmd_start(cmd_start), .cmd_level(cmd_level), .cmd_width(cmd_width), .busy(busy),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_timeout(resp_timeout),
    .irq_seen(irq_seen), .bus(bus_if));
  dma_irq_sva sva_i (.core_clk(core_clk), .srst(srst), .irq_o(bus_if.irq_o),
    .irq_oe(bus_if.irq_oe), .irq_n(bus_if.irq_n), .iack_req(bus_if.iack_req),
    .iack_level(bus_if.iack_level), .iack_width(bus_if.iack_width),
    .iack_dtack(bus_if.iack_dtack), .iack_data(bus_if.iack_data));

  // ------------------------------------------------------------------
  // Clock, hang guard and helpers.
  // ------------------------------------------------------------------
  always #25 core_clk = ~core_clk;

  // The whole run needs about 580 cycles; 6000 leaves room.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Status/ID expected from the mode bits, register contents and address.
  function automatic logic [15:0] exp_iack(input logic b, input logic s, input logic [7:0] id,
                                           input logic [7:0] a);
    if (b) return {8'h00, s ? a : id};
    return {id, a};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One strobe cycle; the answer is sampled once the acknowledging edge has landed.
  task automatic bus_op(input logic wr, input logic [11:0] a, input logic [1:0] be,
                        input logic [15:0] d, output logic [15:0] rq);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("reg_ack", 16'(reg_ack), 16'h0001);
    rq = reg_rdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] rq;
    bus_op(1'b1, a, be, d, rq);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] rq;
    bus_op(1'b0, a, 2'h3, 16'h0000, rq);
    chk(what, rq, exp);
  endtask

  // Runs one acknowledge cycle; ok is low when the handler timed out.
  task automatic iack(input logic [2:0] l, input iack_width_e wd, output logic k,
                      output logic [15:0] d);
    int n;
    logic t;
    @(posedge core_clk);
    cmd_start <= 1'b1;
    cmd_level <= l;
    cmd_width <= wd;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    #1;
    k = 1'b0;
    t = 1'b0;
    d = 16'h0000;
    for (n = 0; n < 40 && busy !== 1'b0; n++) begin
      tick(1);
      if (resp_valid === 1'b1) begin
        k = 1'b1;
        d = resp_data;
      end
      if (resp_timeout === 1'b1) begin
        t = 1'b1;
      end
    end
    // Every cycle ends either answered or timed out, never both or neither.
    chk("iack resolved", 16'(k ^ t), 16'h0001);
  endtask

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    {core_clk, srst, soft_rst, reg_wr, reg_rd, dma_done, cmd_start} = 7'b0100000;
    {reg_addr, reg_be, reg_wdata, logical_addr, cmd_level} = '0;
    cmd_width = IACK_W16;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("config", OFS_IRQ_CONFIG, 16'h0000);
    rd_chk("status_id", OFS_STATUS_ID, 16'h0003);
    rd_chk("unmapped", 12'h004, 16'h0000);
    // Reserved bits and the pending bit ignore writes.
    wr(OFS_IRQ_CONFIG, 2'h3, 16'hffff);
    rd_chk("config ones", OFS_IRQ_CONFIG, 16'he807);
    $display("test reset_and_reserved done");
    // Every level, first in 16-bit then in byte mode; level 0 must stay silent.
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      lvl = 3'(i);
      bm = i[3];
      ss = bm & r[0];
      sid = {r[15:11], 3'h3};
      la = r[23:16];
      w = (bm && r[24]) ? IACK_W8 : (r[25] ? IACK_W32 : IACK_W16);
      cfg = {bm, ss, 1'b1, 1'b0, 1'b1, 8'h00, lvl};
      wr(OFS_STATUS_ID, 2'h1, {8'h00, r[15:8]});
      wr(OFS_IRQ_CONFIG, 2'h3, cfg);
      wr(OFS_IRQ_ENABLE, 2'h2, 16'h0900);
      @(posedge core_clk);
      logical_addr <= la;
      dma_done <= 1'b1;
      tick(3);
      chk("irq_seen", 16'(irq_seen), 16'((16'h0001 << lvl) >> 1));
      chk("irq_pending", 16'(irq_pending), 16'h0001);
      rd_chk("config pending", OFS_IRQ_CONFIG, cfg | 16'h0080);
      if (!bm) begin
        iack(lvl, IACK_W8, ok, q);
        chk("byte iack refused", 16'(ok), 16'h0000);
      end
      iack(lvl, w, ok, q);
      chk("iack answered", 16'(ok), 16'(lvl != 3'h0));
      if (lvl != 3'h0) chk("iack data", q, exp_iack(bm, ss, sid, la));
      tick(1);
      chk("line released", 16'(irq_seen), 16'h0000);
      chk("pending kept", 16'(irq_pending), 16'h0001);
      tick(2);
      chk("pending held", 16'(irq_pending), 16'h0001);
      // Re-arm in order: disable, clear the done condition, enable again.
      wr(OFS_IRQ_ENABLE, 2'h2, 16'h0800);
      tick(1);
      chk("pending while done", 16'(irq_pending), 16'h0001);
      @(posedge core_clk);
      dma_done <= 1'b0;
      tick(2);
      chk("pending rearmed", 16'(irq_pending), 16'h0000);
      wr(OFS_IRQ_ENABLE, 2'h2, 16'h0900);
      tick(2);
      chk("quiet after rearm", 16'(irq_seen), 16'h0000);
      $display("test level %0d byte %0d done", lvl, bm);
    end
    // Soft reset keeps the configuration, hard reset clears it.
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    rd_chk("config soft", OFS_IRQ_CONFIG, cfg);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("config hard", OFS_IRQ_CONFIG, 16'h0000);
    $display("test resets done");
    give_verdict();
  end
endmodule
`default_nettype wire
